// File: verilog/fop_pkg.sv
// Constants, register map and state type of the flag offset programmer.
package fop_pkg;

	localparam int OFS_W = 5;
	localparam int CNT_W = 7;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	localparam logic [OFS_W-1:0] OFS_DEFAULT = 5'h08;
	localparam logic [CNT_W-1:0] FIFO_DEPTH = 7'h40;
	localparam logic [1:0] READY_EDGES = 2'h2;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
	localparam logic [ADDR_W-1:0] REG_OFFSETS = 4'h8;
	localparam logic [ADDR_W-1:0] REG_STATE = 4'hC;

	// Event bits in status and mask.
	localparam int EV_BOTH = 0;
	localparam int EV_FULLONLY = 1;
	localparam int EV_BLOCKED = 2;
	localparam int EV_W = 3;

	// Field positions in the offsets and state registers.
	localparam int FLD_EMPTY_LSB = 0;
	localparam int FLD_FULL_LSB = 8;
	localparam int FLD_COUNT_LSB = 0;
	localparam int FLD_FLAG = 8;
	localparam int FLD_READY = 9;
	localparam int FLD_WRITTEN = 10;
	localparam int FLD_PROG = 11;

	typedef enum logic [1:0] {
		FOP_IDLE,
		FOP_BOTH,
		FOP_HOLD
	} fop_state_e;

endpackage

// File: verilog/fop_sync.sv
// Two-stage synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module fop_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,   // Write clock.
	input  wire logic         rst_b, // Asynchronous reset, active low.
	input  wire logic [W-1:0] pinIn, // Raw pin levels.
	output logic      [W-1:0] synOut // Levels after two flip-flops.
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= INIT;
			sync_q <= INIT;
		end
		else
		begin
			meta_q <= pinIn;
			sync_q <= meta_q;
		end
	end

	assign synOut = sync_q;

endmodule
`default_nettype wire

// File: verilog/fop_offset_prog.sv
// Write-side offset programming, write gating and almost-full/empty flag.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module fop_offset_prog
	import fop_pkg::*;
(
	input  wire logic                      clk,                      // Write clock, 250 MHz.
	input  wire logic                      rst_b,                    // FIFO reset, active low.
	input  wire logic                      offset_program_enable_n,  // Program enable pin, active low.
	input  wire logic [fop_pkg::OFS_W-1:0] offset_value_inputs,      // Low five data pins.
	input  wire logic                      write_enable_active_high, // Write enable pin, active high.
	input  wire logic                      write_enable_active_low,  // Write enable pin, active low.
	input  wire logic [fop_pkg::CNT_W-1:0] wordCount,                // Stored words, same clock.
	output logic                           memWrite,                 // Write one word this cycle.
	output logic                           input_ready_flag,         // High while a write may be taken.
	output logic                           almost_full_empty_flag,   // Combined threshold flag.
	output logic [fop_pkg::OFS_W-1:0]      emptyOffset,              // Almost-empty offset X.
	output logic [fop_pkg::OFS_W-1:0]      fullOffset,               // Almost-full offset Y.
	input  wire logic [fop_pkg::ADDR_W-1:0] regAddr,                 // Register byte address.
	input  wire logic [fop_pkg::DATA_W-1:0] regWrData,               // Register write data.
	input  wire logic                      regWrite,                 // Write strobe.
	input  wire logic                      regRead,                  // Read strobe.
	output logic [fop_pkg::DATA_W-1:0]     regRdData,                // Read data, one cycle after strobe.
	output logic                           irq                       // Interrupt, level, active high.
);

	import fop_pkg::*;

	// Synchronised pin levels; program enable idles high so reset never looks like a request.
	logic             penN;
	logic [OFS_W-1:0] ofsIn;
	logic             wenHigh;
	logic             wenLow;

	fop_sync #(
		.W    (1),
		.INIT (1'b1)
	) u_sync_pen (
		.clk    (clk),
		.rst_b  (rst_b),
		.pinIn  (offset_program_enable_n),
		.synOut (penN)
	);

	fop_sync #(
		.W    (OFS_W + 2),
		.INIT ('0)
	) u_sync_data (
		.clk    (clk),
		.rst_b  (rst_b),
		.pinIn  ({offset_value_inputs, write_enable_active_high, write_enable_active_low}),
		.synOut ({ofsIn, wenHigh, wenLow})
	);

	fop_state_e       state_q;
	fop_state_e       state_d;
	logic [OFS_W-1:0] emptyOfs_q;
	logic [OFS_W-1:0] fullOfs_q;
	logic [1:0]       readyCnt_q;
	logic             ready_q;
	logic             written_q;
	logic             flag_q;
	logic [EV_W-1:0]  status_q;
	logic [EV_W-1:0]  mask_q;
	logic [DATA_W-1:0] rdData_q;

	// Flag threshold test, shared by the next-value logic.
	function automatic logic flagFor(
		input logic [CNT_W-1:0] cnt,
		input logic [OFS_W-1:0] x,
		input logic [OFS_W-1:0] y
	);
		flagFor = (cnt <= {2'h0, x}) || (cnt >= (FIFO_DEPTH - {2'h0, y}));
	endfunction

	// Programming is accepted only after reset and before the first written word.
	wire progWindow = !written_q;
	wire progActive = !penN && progWindow;
	wire capBoth = progActive && (state_q == FOP_IDLE);
	wire capFull = progActive && (state_q == FOP_BOTH);
	wire memFull = (wordCount >= FIFO_DEPTH);
	wire wantWrite = wenHigh && !wenLow;
	wire blocked = wantWrite && progActive;

	// Writes are gated by readiness and by programming; full drops readiness.
	assign memWrite = wantWrite && ready_q && !progActive;

	// Capture sequence: first edge loads both, second edge loads Y only.
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			FOP_IDLE:
				if (capBoth)
					state_d = FOP_BOTH;
			FOP_BOTH:
				if (penN)
					state_d = FOP_IDLE;
				else
					state_d = FOP_HOLD;
			FOP_HOLD:
				if (penN)
					state_d = FOP_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= FOP_IDLE;
		else
			state_q <= state_d;
	end

	// Offsets reset to the default and change only on capture edges; five bits bound them to 31.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			emptyOfs_q <= OFS_DEFAULT;
			fullOfs_q <= OFS_DEFAULT;
		end
		else if (capBoth)
		begin
			emptyOfs_q <= ofsIn;
			fullOfs_q <= ofsIn;
		end
		else if (capFull)
		begin
			fullOfs_q <= ofsIn;
		end
	end

	// Readiness rises on the second edge after reset, then follows the full state.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			readyCnt_q <= 2'h0;
			ready_q <= 1'b0;
		end
		else
		begin
			if (readyCnt_q != READY_EDGES)
				readyCnt_q <= readyCnt_q + 2'h1;
			ready_q <= (readyCnt_q >= (READY_EDGES - 2'h1)) && !memFull;
		end
	end

	// Once a word lands, the programming window closes until the next reset.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			written_q <= 1'b0;
		else if (memWrite)
			written_q <= 1'b1;
	end

	// The flag is high after reset because an empty memory is at or below any offset.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			flag_q <= 1'b1;
		else
			flag_q <= flagFor(wordCount, emptyOfs_q, fullOfs_q);
	end

	// Register decode.
	wire selStatus = (regAddr == REG_STATUS);
	wire selMask = (regAddr == REG_MASK);
	wire selOffsets = (regAddr == REG_OFFSETS);
	wire selState = (regAddr == REG_STATE);
	wire [EV_W-1:0] events = {blocked, capFull, capBoth};
	wire [EV_W-1:0] clearBits = (regWrite && selStatus) ? regWrData[EV_W-1:0] : '0;

	// Sticky events; a set in the cycle of a clear wins.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_q <= '0;
			mask_q <= '0;
		end
		else
		begin
			status_q <= (status_q & ~clearBits) | events;
			if (regWrite && selMask)
				mask_q <= regWrData[EV_W-1:0];
		end
	end

	// Read mux; unmapped addresses read zero.
	wire [DATA_W-1:0] rdStatus = {{(DATA_W-EV_W){1'b0}}, status_q};
	wire [DATA_W-1:0] rdMask = {{(DATA_W-EV_W){1'b0}}, mask_q};
	wire [DATA_W-1:0] rdOffsets = (DATA_W'(fullOfs_q) << FLD_FULL_LSB) | (DATA_W'(emptyOfs_q) << FLD_EMPTY_LSB);
	wire [DATA_W-1:0] rdState = (DATA_W'(wordCount) << FLD_COUNT_LSB) | (DATA_W'(flag_q) << FLD_FLAG)
		| (DATA_W'(ready_q) << FLD_READY) | (DATA_W'(written_q) << FLD_WRITTEN)
		| (DATA_W'(progActive) << FLD_PROG);
	wire [DATA_W-1:0] rdMux = selStatus ? rdStatus :
		selMask ? rdMask :
		selOffsets ? rdOffsets :
		selState ? rdState : '0;

	// Read data stand for exactly the cycle after the strobe, else zero.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdData_q <= '0;
		else if (regRead)
			rdData_q <= rdMux;
		else
			rdData_q <= '0;
	end

	assign input_ready_flag = ready_q;
	assign almost_full_empty_flag = flag_q;
	assign emptyOffset = emptyOfs_q;
	assign fullOffset = fullOfs_q;
	assign regRdData = rdData_q;
	assign irq = |(status_q & mask_q);

endmodule
`default_nettype wire

// File: tb/fop_offset_prog_monitor.sv
// Port-level assertions for the flag offset programmer.
`timescale 1ns/1ns
`default_nettype none
module fop_offset_prog_monitor
	import fop_pkg::*;
(
	input  wire logic             clk,                     // Write clock.
	input  wire logic             rst_b,                   // Reset, active low.
	input  wire logic             offset_program_enable_n, // Program enable pin.
	input  wire logic [OFS_W-1:0] offset_value_inputs,     // Offset data pins.
	input  wire logic [CNT_W-1:0] wordCount,               // Stored words.
	input  wire logic             memWrite,                // Word write.
	input  wire logic             input_ready_flag,        // Input ready.
	input  wire logic             almost_full_empty_flag,  // Threshold flag.
	input  wire logic [OFS_W-1:0] emptyOffset,             // Offset X.
	input  wire logic [OFS_W-1:0] fullOffset               // Offset Y.
);
	logic wrote_q;
	logic flagCond;
	// Threshold the flag register must follow one cycle later.
	assign flagCond = ({2'h0, emptyOffset} >= wordCount) || (wordCount >= FIFO_DEPTH - {2'h0, fullOffset});
	// Remembers the first write, after which the offsets are frozen.
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			wrote_q <= 1'h0;
		else if (memWrite)
			wrote_q <= 1'h1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Enable seen low at the pin has reached the block two edges later.
	sequence s_prog_seen;
		!offset_program_enable_n ##2 !wrote_q;
	endsequence
	chk_ready_full: assert property (wordCount >= FIFO_DEPTH |=> !input_ready_flag)
		else $error("ready high while full");
	chk_write_ready: assert property (memWrite |-> input_ready_flag)
		else $error("write without ready");
	chk_flag_value: assert property ($past(rst_b) |-> almost_full_empty_flag == $past(flagCond))
		else $error("flag wrong");
	chk_both_capture: assert property ($changed(emptyOffset) |-> emptyOffset == $past(offset_value_inputs, 3) && fullOffset == emptyOffset)
		else $error("first capture wrong");
	chk_full_only: assert property ($changed(fullOffset) && $stable(emptyOffset) |-> fullOffset == $past(offset_value_inputs, 3))
		else $error("second capture wrong");
	chk_default_ofs: assert property (!$past(rst_b) |-> emptyOffset == OFS_DEFAULT && fullOffset == OFS_DEFAULT)
		else $error("default offsets wrong");
	chk_no_write_prog: assert property (s_prog_seen |-> !memWrite)
		else $error("write while programming");
	chk_offsets_frozen: assert property (wrote_q |=> $stable(emptyOffset) && $stable(fullOffset))
		else $error("offsets moved after write");
endmodule
`default_nettype wire

// File: tb/fop_ctrl_model.sv
// Write-side controller model driving the program and write pins.
`timescale 1ns/1ns
`default_nettype none
module fop_ctrl_model
	import fop_pkg::*;
(
	input  wire logic             clk,   // Write clock.
	input  wire logic             rst_b, // Reset, active low.
	input  wire logic             ready, // Input ready from the block.
	input  wire logic             prog,  // Bench asks to program.
	input  wire logic [OFS_W-1:0] val,   // Offset to present.
	input  wire logic             wr,    // Bench asks to write.
	output logic                  penN,  // Program enable pin.
	output logic [OFS_W-1:0]      data,  // Offset data pins.
	output logic                  wenH,  // Write enable, active high.
	output logic                  wenL   // Write enable, active low.
);
	// Pins move on the falling edge, so enable only drops while the clock is low.
	always_ff @(negedge clk or negedge rst_b)
		if (!rst_b)
		begin
			penN <= 1'h1;
			data <= 5'h00;
			wenH <= 1'h0;
			wenL <= 1'h1;
		end
		else
		begin
			penN <= !(prog && ready);
			data <= val;
			wenH <= wr;
			wenL <= !wr;
		end
endmodule
`default_nettype wire

// File: tb/tb_fop_offset_prog.sv
// Self-checking bench for the flag offset programmer.
`timescale 1ns/1ns
`default_nettype none
module tb_fop_offset_prog;
	import fop_pkg::*;
	logic clk, rst_b, prog, wr, regWrite, regRead;
	logic [4:0] val;
	logic [6:0] cnt;
	logic [3:0] regAddr;
	logic [31:0] regWrData;
	wire logic [31:0] regRdData;
	wire logic penN, wenH, wenL, memWrite, ready, flag, irq;
	wire logic [4:0] data, xOfs, yOfs;
	int errors = 0;
	int num_checks = 0;
	int cycles = 0;
	fop_offset_prog i_dut (.clk(clk), .rst_b(rst_b), .offset_program_enable_n(penN), .offset_value_inputs(data),
		.write_enable_active_high(wenH), .write_enable_active_low(wenL), .wordCount(cnt), .memWrite(memWrite),
		.input_ready_flag(ready), .almost_full_empty_flag(flag), .emptyOffset(xOfs), .fullOffset(yOfs),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.irq(irq));
	fop_ctrl_model i_ctrl (.clk(clk), .rst_b(rst_b), .ready(ready), .prog(prog), .val(val), .wr(wr),
		.penN(penN), .data(data), .wenH(wenH), .wenL(wenL));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task wreg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk); regAddr <= a; regWrData <= d; regWrite <= 1'h1;
		@(posedge clk); regWrite <= 1'h0;
		#1;
	endtask
	task rreg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk); regAddr <= a; regRead <= 1'h1;
		@(posedge clk); regRead <= 1'h0;
		#1 chk(regRdData, e);
	endtask
	// Programs X then Y with a write attempt inside the programming window.
	task t_program;
		@(posedge clk); prog <= 1'h1; val <= 5'h00; wr <= 1'h1;
		@(posedge clk); val <= 5'h1F;
		@(posedge clk); prog <= 1'h0; wr <= 1'h0;
		repeat (4) @(posedge clk);
		#1 chk(32'(xOfs), 32'h0);
		chk(32'(yOfs), 32'h1F);
		rreg(REG_STATUS, 32'h7);
		rreg(REG_OFFSETS, 32'h1F00);
		wreg(REG_MASK, 32'h4);
		chk(32'(irq), 32'h1);
		wreg(REG_STATUS, 32'h4);
		chk(32'(irq), 32'h0);
		$display("test program done");
	endtask
	// Flag thresholds with X of 0 and Y of 31, so the upper bound is 33.
	task t_flag;
		logic [6:0] c [5];
		logic e [5];
		c = '{7'h00, 7'h01, 7'h20, 7'h21, 7'h40};
		e = '{1'h1, 1'h0, 1'h0, 1'h1, 1'h1};
		for (int i = 0; i < 5; i++)
		begin
			@(posedge clk); cnt <= c[i];
			repeat (2) @(posedge clk);
			#1 chk(32'(flag), 32'(e[i]));
		end
		$display("test flag done");
	endtask
	// Writes freeze the offsets; a full memory drops ready and blocks writes.
	task t_write;
		@(posedge clk); cnt <= 7'h05; wr <= 1'h1;
		repeat (3) @(posedge clk);
		#1 chk(32'(memWrite), 32'h1);
		@(posedge clk); prog <= 1'h1; val <= 5'h09;
		repeat (5) @(posedge clk); prog <= 1'h0;
		#1 chk(32'({yOfs, xOfs}), 32'h3E0);
		@(posedge clk); cnt <= FIFO_DEPTH;
		repeat (2) @(posedge clk);
		#1 chk(32'({ready, memWrite}), 32'h0);
		wr <= 1'h0;
		rreg(REG_STATE, 32'h540);
		$display("test write done");
	endtask
	// Clock of 4 ns period.
	initial
	begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	// Bounds the run in case the block hangs.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			print_verdict;
		end
	end
	// Reset, then the scenarios in order.
	initial
	begin
		{rst_b, prog, wr, regWrite, regRead} = 5'h0;
		val = 5'h00;
		cnt = 7'h00;
		regAddr = 4'h0;
		regWrData = 32'h0;
		repeat (12) @(posedge clk);
		chk(32'({flag, ready, yOfs, xOfs}), 32'h908);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		#1 chk(32'(ready), 32'h1);
		rreg(REG_OFFSETS, 32'h0808);
		rreg(4'h2, 32'h0);
		$display("test reset done");
		t_program();
		t_flag();
		t_write();
		print_verdict;
	end
endmodule
bind fop_offset_prog fop_offset_prog_monitor i_mon (.clk(clk), .rst_b(rst_b),
	.offset_program_enable_n(offset_program_enable_n), .offset_value_inputs(offset_value_inputs),
	.wordCount(wordCount), .memWrite(memWrite), .input_ready_flag(input_ready_flag),
	.almost_full_empty_flag(almost_full_empty_flag), .emptyOffset(emptyOffset), .fullOffset(fullOffset));
`default_nettype wire
